// ---- rtl/adcc_pkg.sv ----
// Constants, types and register map of the converter control block
//------------------------------------------------------------------
// Contract
// - Six analog-enable bits each make one port pin analog; top two bits read zero.
// - Pin 0 priority: external interrupt first, then analog channel 0, then digital.
// - Reference bit 0 uses supply, shared pin digital; 1 takes reference from pin.
// - Clock-rate code: 00 divide 4 default, 01 by 1, 10 by 16, 11 by 2.
// - Writing 1 to the run bit starts converting the selected channel.
// - Only completion clears the run bit; software writing 0 does nothing.
// - Power bit 0 switches off the resistor reference; 1 keeps converter on.
// - Channel codes 000 to 101 pick inputs 0 to 5; 110, 111 pick none.
// - Reference function beats digital I/O on the shared reference pin when selected.
// - On completion result bits 9 to 2 load into the high result buffer.
// - Completion also clears the run bit and sets the done flag.
// - High result buffer is read-only; writes leave it unchanged.
// - Low result buffer holds result bits 1 and 0, read-only.
// - Low result buffer bits 7 to 2 always read zero.
// - Done flag at status bit 6, set by hardware, cleared only by software.
//------------------------------------------------------------------
package adcc_pkg;

  localparam logic [7:0] ADCC_OFS_PIN_SEL  = 8'h05;
  localparam logic [7:0] ADCC_OFS_CTRL     = 8'h06;
  localparam logic [7:0] ADCC_OFS_RES_HIGH = 8'h08;
  localparam logic [7:0] ADCC_OFS_RES_LOW  = 8'h09;
  localparam logic [7:0] ADCC_OFS_STATUS   = 8'h0A;
  localparam logic [7:0] ADCC_OFS_MASK     = 8'h0B;

  localparam int ADCC_BIT_REF_SEL  = 7;
  localparam int ADCC_BIT_DIV_HI   = 6;
  localparam int ADCC_BIT_DIV_LO   = 5;
  localparam int ADCC_BIT_RUN      = 4;
  localparam int ADCC_BIT_POWER    = 3;
  localparam int ADCC_BIT_CHAN_HI  = 2;
  localparam int ADCC_BIT_DONE     = 6;

  localparam logic [7:0] ADCC_RST_PIN_SEL = 8'h00;
  localparam logic [7:0] ADCC_RST_CTRL    = 8'h00;
  localparam logic [7:0] ADCC_RST_STATUS  = 8'h00;
  localparam logic [7:0] ADCC_RST_MASK    = 8'h00;
  localparam logic [7:0] ADCC_PIN_SEL_USED = 8'h3F;
  localparam logic [7:0] ADCC_STATUS_USED  = 8'h40;

  localparam logic [1:0] ADCC_DIV_CODE_4  = 2'h0;
  localparam logic [1:0] ADCC_DIV_CODE_1  = 2'h1;
  localparam logic [1:0] ADCC_DIV_CODE_16 = 2'h2;
  localparam logic [1:0] ADCC_DIV_CODE_2  = 2'h3;
  localparam logic [3:0] ADCC_DIV_TERM_4  = 4'h3;
  localparam logic [3:0] ADCC_DIV_TERM_1  = 4'h0;
  localparam logic [3:0] ADCC_DIV_TERM_16 = 4'hF;
  localparam logic [3:0] ADCC_DIV_TERM_2  = 4'h1;
  localparam logic [2:0] ADCC_CHAN_LAST   = 3'h5;

  typedef enum logic [1:0] {ADCC_PIN0_DIGITAL, ADCC_PIN0_ANALOG, ADCC_PIN0_EXT_INT} adcc_pin0_t;

  typedef struct packed {
    logic       power_on;
    logic       ref_ext;
    logic       start;
    logic       clk_en;
    logic       channel_valid;
    logic [2:0] channel;
  } adcc_core_ctrl_t;

  typedef struct packed {
    logic       done;
    logic [9:0] data;
  } adcc_core_res_t;

endpackage : adcc_pkg

// ---- rtl/adcc_ctrl.sv ----
// Converter control block: registers, clock prescaler, start/done handshake, pins
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module adcc_ctrl
  import adcc_pkg::*;
(
  input  wire logic            clk_sys_i,
  input  wire logic            rstn_i,
  input  wire logic [7:0]      addr_i,
  input  wire logic [7:0]      wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output logic      [7:0]      rdata_o,
  input  wire logic            ext_int_en_i,
  input  wire adcc_core_res_t  core_res_i,
  output adcc_core_ctrl_t      core_ctrl_o,
  output logic      [5:0]      analog_enable_o,
  output adcc_pin0_t           pin0_func_o,
  output logic                 ref_pin_digital_o,
  output logic      [9:0]      result_o,
  output logic                 irq_o
);

  //----------------------------------------------------------------
  // Register storage
  //----------------------------------------------------------------
  logic [7:0] pin_sel;
  logic [7:0] ctrl;
  logic [7:0] res_high;
  logic [1:0] res_low;
  logic [7:0] status;
  logic [7:0] mask;
  logic [3:0] div_cnt;
  logic [3:0] div_term;
  logic       done_ev;
  logic       wr_ctrl;
  logic       start_req;
  logic       rd_status;

  function automatic logic [3:0] div_terminal(input logic [1:0] code);
    case (code)
      ADCC_DIV_CODE_1:  div_terminal = ADCC_DIV_TERM_1;
      ADCC_DIV_CODE_16: div_terminal = ADCC_DIV_TERM_16;
      ADCC_DIV_CODE_2:  div_terminal = ADCC_DIV_TERM_2;
      default:          div_terminal = ADCC_DIV_TERM_4;
    endcase
  endfunction : div_terminal

  function automatic logic sel(input logic [7:0] a, input logic [7:0] ofs);
    sel = (a == ofs);
  endfunction : sel

  assign div_term  = div_terminal(ctrl[ADCC_BIT_DIV_HI:ADCC_BIT_DIV_LO]);
  assign done_ev   = core_res_i.done && ctrl[ADCC_BIT_RUN];
  assign wr_ctrl   = wr_i && sel(addr_i, ADCC_OFS_CTRL);
  assign start_req = wr_ctrl && wdata_i[ADCC_BIT_RUN] && !ctrl[ADCC_BIT_RUN];
  assign rd_status = rd_i && sel(addr_i, ADCC_OFS_STATUS);

  //----------------------------------------------------------------
  // Pin select register
  //----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_sel <= ADCC_RST_PIN_SEL;
    end else if (wr_i && sel(addr_i, ADCC_OFS_PIN_SEL)) begin
      pin_sel <= wdata_i & ADCC_PIN_SEL_USED;
    end
  end

  chk_pin_sel_write: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == ADCC_OFS_PIN_SEL |=> pin_sel == ($past(wdata_i) & ADCC_PIN_SEL_USED))
    else $error("pin select write wrong or top bits kept");

  //----------------------------------------------------------------
  // Control register
  //----------------------------------------------------------------
  // Run bit: a written 0 is dropped, completion is the only way down
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl <= ADCC_RST_CTRL;
    end else begin
      if (wr_ctrl) begin
        ctrl[7:5] <= wdata_i[7:5];
        ctrl[3:0] <= wdata_i[3:0];
      end
      if (start_req) begin
        ctrl[ADCC_BIT_RUN] <= 1'b1;
      end else if (done_ev) begin
        ctrl[ADCC_BIT_RUN] <= 1'b0;
      end
    end
  end

  chk_run_zero_write: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    wr_ctrl && !wdata_i[ADCC_BIT_RUN] && ctrl[ADCC_BIT_RUN] && !done_ev |=> ctrl[ADCC_BIT_RUN])
    else $error("software write of zero cleared the run bit");

  chk_start_only_idle: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    core_ctrl_o.start |-> !$past(ctrl[ADCC_BIT_RUN]))
    else $error("start issued while a conversion was running");

  //----------------------------------------------------------------
  // Result buffers
  //----------------------------------------------------------------
  // No write path exists, so both buffers are read-only
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      res_high <= 8'h00;
      res_low  <= 2'h0;
    end else if (done_ev) begin
      res_high <= core_res_i.data[9:2];
      res_low  <= core_res_i.data[1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      result_o <= 10'h000;
    end else if (done_ev) begin
      result_o <= {core_res_i.data[9:2], core_res_i.data[1:0]};
    end
  end

  chk_low_load: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    done_ev |=> res_low == $past(core_res_i.data[1:0]))
    else $error("low buffer not loaded on completion");

  chk_buffers_read_only: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !done_ev |=> $stable(res_high) && $stable(res_low))
    else $error("result buffer changed without completion");

  chk_result_join: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    done_ev |=> result_o == {res_high, res_low})
    else $error("full result differs from the buffers");

  //----------------------------------------------------------------
  // Status and mask
  //----------------------------------------------------------------
  // Completion in the same cycle as a clearing read wins
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status <= ADCC_RST_STATUS;
    end else if (done_ev) begin
      status[ADCC_BIT_DONE] <= 1'b1;
    end else if (rd_status) begin
      status <= ADCC_RST_STATUS;
    end
  end

  chk_done_stays: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    status[ADCC_BIT_DONE] && !rd_status |=> status[ADCC_BIT_DONE])
    else $error("done flag dropped without a status read");

  chk_done_no_set: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !status[ADCC_BIT_DONE] && !done_ev |=> !status[ADCC_BIT_DONE])
    else $error("done flag set without completion");

  chk_done_read_clear: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    rd_status && !done_ev |=> !status[ADCC_BIT_DONE])
    else $error("status read did not clear the done flag");

  chk_set_beats_clear: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    rd_status && done_ev |=> status[ADCC_BIT_DONE])
    else $error("completion lost against a clearing read");

  // Mask bit 6 doubles as the wake enable for completion
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask <= ADCC_RST_MASK;
    end else if (wr_i && sel(addr_i, ADCC_OFS_MASK)) begin
      mask <= wdata_i & ADCC_STATUS_USED;
    end
  end

  chk_mask_write: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == ADCC_OFS_MASK |=> mask == ($past(wdata_i) & ADCC_STATUS_USED))
    else $error("mask write wrong");

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

  // One cycle behind the flag, so the output stays a clean register
  chk_irq_level: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    1'b1 |=> irq_o == (|$past(status & mask)))
    else $error("interrupt level does not follow masked status");

  //----------------------------------------------------------------
  // Read port
  //----------------------------------------------------------------
  // Data stand for one cycle only; unmapped addresses read zero
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ADCC_OFS_PIN_SEL:  rdata_o <= pin_sel;
        ADCC_OFS_CTRL:     rdata_o <= ctrl;
        ADCC_OFS_RES_HIGH: rdata_o <= res_high;
        ADCC_OFS_RES_LOW:  rdata_o <= {6'h00, res_low};
        ADCC_OFS_STATUS:   rdata_o <= status;
        ADCC_OFS_MASK:     rdata_o <= mask;
        default:           rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  chk_status_read: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    rd_status |=> rdata_o == $past(status))
    else $error("status read returned the wrong value");

  //----------------------------------------------------------------
  // Converter clock prescaler
  //----------------------------------------------------------------
  // Compare with >= so a smaller code taking effect mid-count recovers
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_cnt <= 4'h0;
    end else if (div_cnt >= div_term) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // Writes abort these, since a new code may land mid-count
  chk_div1_period: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i || wr_i)
    core_ctrl_o.clk_en && ctrl[6:5] == ADCC_DIV_CODE_1 |=> core_ctrl_o.clk_en)
    else $error("divide by one period wrong");

  chk_div2_period: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i || wr_i)
    core_ctrl_o.clk_en && ctrl[6:5] == ADCC_DIV_CODE_2 && div_cnt == 4'h0
    |=> !core_ctrl_o.clk_en ##1 core_ctrl_o.clk_en)
    else $error("divide by two period wrong");

  chk_div16_period: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i || wr_i)
    core_ctrl_o.clk_en && ctrl[6:5] == ADCC_DIV_CODE_16 && div_cnt == 4'h0
    |=> !core_ctrl_o.clk_en [*8] ##1 !core_ctrl_o.clk_en [*7] ##1 core_ctrl_o.clk_en)
    else $error("divide by sixteen period wrong");

  //----------------------------------------------------------------
  // Core control and pin functions
  //----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_ctrl_o <= '0;
    end else begin
      core_ctrl_o.clk_en        <= (div_cnt >= div_term);
      core_ctrl_o.start         <= start_req;
      core_ctrl_o.power_on      <= ctrl[ADCC_BIT_POWER];
      core_ctrl_o.ref_ext       <= ctrl[ADCC_BIT_REF_SEL];
      core_ctrl_o.channel       <= ctrl[ADCC_BIT_CHAN_HI:0];
      core_ctrl_o.channel_valid <= (ctrl[ADCC_BIT_CHAN_HI:0] <= ADCC_CHAN_LAST);
    end
  end

  chk_power_follow: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    1'b1 |=> core_ctrl_o.power_on == $past(ctrl[ADCC_BIT_POWER]))
    else $error("power control not passed to the core");

  chk_chan_valid: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    ctrl[ADCC_BIT_CHAN_HI:0] <= ADCC_CHAN_LAST
    |=> core_ctrl_o.channel_valid && core_ctrl_o.channel == $past(ctrl[ADCC_BIT_CHAN_HI:0]))
    else $error("defined channel not selected");

  chk_ref_pin_release: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !ctrl[ADCC_BIT_REF_SEL] |=> ref_pin_digital_o && !core_ctrl_o.ref_ext)
    else $error("supply reference not selected");

  // Pin 0 carries the external interrupt too, which outranks analog
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      analog_enable_o   <= 6'h00;
      pin0_func_o       <= ADCC_PIN0_DIGITAL;
      ref_pin_digital_o <= 1'b1;
    end else begin
      analog_enable_o[5:1] <= pin_sel[5:1];
      analog_enable_o[0]   <= pin_sel[0] && !ext_int_en_i;
      if (ext_int_en_i) begin
        pin0_func_o <= ADCC_PIN0_EXT_INT;
      end else if (pin_sel[0]) begin
        pin0_func_o <= ADCC_PIN0_ANALOG;
      end else begin
        pin0_func_o <= ADCC_PIN0_DIGITAL;
      end
      ref_pin_digital_o <= !ctrl[ADCC_BIT_REF_SEL];
    end
  end

  chk_analog_follow: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    1'b1 |=> analog_enable_o[5:1] == $past(pin_sel[5:1]))
    else $error("analog enables do not follow pin select");

  chk_pin0_analog: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !ext_int_en_i && pin_sel[0] |=> analog_enable_o[0] && pin0_func_o == ADCC_PIN0_ANALOG)
    else $error("analog lost pin 0 to digital");

  chk_pin0_digital: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !ext_int_en_i && !pin_sel[0] |=> !analog_enable_o[0] && pin0_func_o == ADCC_PIN0_DIGITAL)
    else $error("pin 0 not left as digital");

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  chk_run_start_pulse: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    start_req |=> core_ctrl_o.start && ctrl[ADCC_BIT_RUN] ##1 !core_ctrl_o.start)
    else $error("run write did not start a conversion");

  chk_run_clear_done: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(ctrl[ADCC_BIT_RUN]) |-> $past(core_res_i.done))
    else $error("run bit cleared without completion");

  chk_result_high_load: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    done_ev |=> res_high == $past(core_res_i.data[9:2]) && !ctrl[ADCC_BIT_RUN])
    else $error("high buffer not loaded on completion");

  chk_done_flag_set: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    done_ev |=> status[ADCC_BIT_DONE] ##1 irq_o == $past(mask[ADCC_BIT_DONE]))
    else $error("done flag or interrupt missing");

  chk_low_read_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    rd_i && addr_i == ADCC_OFS_RES_LOW
    |=> rdata_o[7:2] == 6'h00 && rdata_o[1:0] == $past(res_low))
    else $error("low buffer upper bits not zero");

  chk_pin0_priority: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    ext_int_en_i |=> !analog_enable_o[0] && pin0_func_o == ADCC_PIN0_EXT_INT)
    else $error("external interrupt lost pin 0");

  chk_div4_period: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i || wr_i)
    core_ctrl_o.clk_en && ctrl[6:5] == ADCC_DIV_CODE_4 && div_cnt == 4'h0
    |=> !core_ctrl_o.clk_en [*3] ##1 core_ctrl_o.clk_en)
    else $error("divide by four period wrong");

  chk_chan_invalid: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    ctrl[2:1] == 2'h3 |=> !core_ctrl_o.channel_valid)
    else $error("undefined channel flagged valid");

  chk_ref_pin_follow: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    ctrl[ADCC_BIT_REF_SEL] |=> !ref_pin_digital_o && core_ctrl_o.ref_ext)
    else $error("reference pin not taken over");

endmodule : adcc_ctrl

// ---- tb/adcc_core_model.sv ----
// Behavioural model of the analog converter core
`timescale 1ns/1ps
module adcc_core_model
  import adcc_pkg::*;
#(
  parameter int LATENCY = 8
)
(
  input  wire logic            clk_sys_i,
  input  wire logic            rstn_i,
  input  wire adcc_core_ctrl_t core_ctrl_i,
  input  wire logic [9:0]      value_i,
  output adcc_core_res_t       core_res_o,
  output int                   starts_o
);
  int   left;
  logic busy;
  // Data toggles outside done so a stale value never looks valid
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy       <= 1'b0;
      left       <= 0;
      starts_o   <= 0;
      core_res_o <= '0;
    end else begin
      if (core_ctrl_i.start) begin
        busy     <= 1'b1;
        left     <= LATENCY;
        starts_o <= starts_o + 1;
      end else if (busy && core_ctrl_i.clk_en) begin
        left <= left - 1;
        if (left == 1) begin
          busy <= 1'b0;
        end
      end
      if (!core_ctrl_i.start && busy && core_ctrl_i.clk_en && left == 1) begin
        core_res_o <= '{done: 1'b1, data: value_i};
      end else begin
        core_res_o <= '{done: 1'b0, data: ~core_res_o.data};
      end
    end
  end
endmodule : adcc_core_model

// ---- tb/adc_control_interface_tb.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_control_interface_tb
  import adcc_pkg::*;
;
  logic            clk_sys_i;
  logic            rstn_i;
  logic            wr_i;
  logic            rd_i;
  logic            ext_int_en_i;
  logic            ref_pin_digital_o;
  logic            irq_o;
  logic [7:0]      addr_i;
  logic [7:0]      wdata_i;
  logic [7:0]      rdata_o;
  logic [5:0]      analog_enable_o;
  logic [9:0]      result_o;
  logic [9:0]      value;
  adcc_core_res_t  core_res_i;
  adcc_core_ctrl_t core_ctrl_o;
  adcc_pin0_t      pin0_func_o;
  int              bad_count;
  int              tests_run;
  int              starts;
  int              n;

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  adcc_ctrl uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_int_en_i(ext_int_en_i),
    .core_res_i(core_res_i), .core_ctrl_o(core_ctrl_o), .analog_enable_o(analog_enable_o),
    .pin0_func_o(pin0_func_o), .ref_pin_digital_o(ref_pin_digital_o), .result_o(result_o),
    .irq_o(irq_o));

  adcc_core_model core (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .core_ctrl_i(core_ctrl_o),
    .value_i(value), .core_res_o(core_res_i), .starts_o(starts));

  // --------
  // Tasks
  // --------
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    check(what, rdata_o, exp);
  endtask : rd

  // Fields reach the pins two edges after the write
  task settle;
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask : settle

  task t_reset;
    rd(ADCC_OFS_PIN_SEL, 8'h00, "pin_sel");
    rd(ADCC_OFS_CTRL, 8'h00, "ctrl");
    rd(ADCC_OFS_MASK, 8'h00, "mask");
    wr(ADCC_OFS_STATUS, 8'h40);
    rd(ADCC_OFS_STATUS, 8'h00, "status");
    rd(8'h07, 8'h00, "unmapped");
    check("ref_pin", ref_pin_digital_o, 1'b1);
    $display("test reset done");
  endtask : t_reset

  task t_pins;
    wr(ADCC_OFS_PIN_SEL, 8'hFF);
    rd(ADCC_OFS_PIN_SEL, 8'h3F, "pin_sel");
    settle;
    check("enable", analog_enable_o, 6'h3F);
    check("pin0", pin0_func_o, ADCC_PIN0_ANALOG);
    @(posedge clk_sys_i);
    ext_int_en_i <= 1'b1;
    settle;
    check("enable", analog_enable_o, 6'h3E);
    check("pin0", pin0_func_o, ADCC_PIN0_EXT_INT);
    wr(ADCC_OFS_PIN_SEL, 8'h20);
    ext_int_en_i <= 1'b0;
    settle;
    check("enable", analog_enable_o, 6'h20);
    check("pin0", pin0_func_o, ADCC_PIN0_DIGITAL);
    $display("test pins done");
  endtask : t_pins

  task t_ctrl;
    logic [7:0] v;
    for (int c = 0; c < 8; c++) begin
      v = {c[0], 3'h0, c[1], c[2:0]};
      wr(ADCC_OFS_CTRL, v);
      rd(ADCC_OFS_CTRL, v, "ctrl");
      settle;
      check("channel", core_ctrl_o.channel, v[2:0]);
      check("valid", core_ctrl_o.channel_valid, c < 6);
      check("power", core_ctrl_o.power_on, v[3]);
      check("ref_ext", core_ctrl_o.ref_ext, v[7]);
      check("ref_pin", ref_pin_digital_o, !v[7]);
    end
    $display("test ctrl done");
  endtask : t_ctrl

  task t_div;
    int per[4];
    per = '{4, 1, 16, 2};
    for (int k = 0; k < 4; k++) begin
      wr(ADCC_OFS_CTRL, {1'b0, k[1:0], 5'h08});
      repeat (20) @(posedge clk_sys_i);
      n = 0;
      repeat (64) begin
        @(posedge clk_sys_i);
        #1;
        n += core_ctrl_o.clk_en;
      end
      check("clk_en", n, 64 / per[k]);
    end
    $display("test divider done");
  endtask : t_div

  task t_conv;
    int s0;
    s0 = starts;
    wr(ADCC_OFS_MASK, 8'h40);
    // Slowest converter clock, the code meant for the fastest oscillator
    wr(ADCC_OFS_CTRL, 8'h5A);
    wr(ADCC_OFS_CTRL, 8'h48);
    rd(ADCC_OFS_CTRL, 8'h58, "run");
    check("start", starts, s0 + 1);
    wr(ADCC_OFS_CTRL, 8'h58);
    n = 0;
    while (irq_o !== 1'b1 && n < 200) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    check("irq", irq_o, 1'b1);
    check("start", starts, s0 + 1);
    check("result", result_o, value);
    wr(ADCC_OFS_RES_HIGH, 8'hFF);
    rd(ADCC_OFS_RES_HIGH, value[9:2], "high");
    rd(ADCC_OFS_RES_LOW, {6'h00, value[1:0]}, "low");
    rd(ADCC_OFS_CTRL, 8'h48, "run");
    rd(ADCC_OFS_STATUS, 8'h40, "status");
    rd(ADCC_OFS_STATUS, 8'h00, "status");
    @(posedge clk_sys_i);
    #1;
    check("irq", irq_o, 1'b0);
    $display("test conversion done");
  endtask : t_conv

  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  initial begin
    rstn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    ext_int_en_i = 1'b0;
    value = 10'h2B5;
    bad_count = 0;
    tests_run = 0;
    repeat (6) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_reset;
    t_pins;
    t_ctrl;
    t_div;
    t_conv;
    stop_test;
  end

  // Whole run is under a thousand cycles
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
endmodule : adc_control_interface_tb
